// ### hdl/sfh_pkg.sv
// package for the serial flash host port: opcodes, field positions, timing
// assumes a single core clock; both ends import it whole
package sfh_pkg;
  // ****************************************************************
  // opcodes and widths
  // ****************************************************************
  localparam logic [7:0] OP_DUAL_OUT  = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO   = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT  = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO   = 8'hEB;
  localparam logic [7:0] OP_QUAD_LD   = 8'h32;
  localparam logic [7:0] OP_QUAD_LDR  = 8'h34;
  localparam logic [7:0] OP_WRITE_REG = 8'h1F;
  localparam logic [7:0] OP_READ_REG  = 8'h0F;
  localparam int         BYTE_W       = 8;
  localparam logic [2:0] BIT_TOP      = 3'h7;
  localparam logic [3:0] ONE_HOT0     = 4'h1;
  // ****************************************************************
  // protection register layout
  // ****************************************************************
  localparam int         PR_HW_EN_BIT = 1;
  localparam int         PR_GUARD_LO  = 2;
  localparam int         PR_GUARD_HI  = 6;
  localparam logic [7:0] PR_RESET     = 8'h7C;
  // ****************************************************************
  // lane width codes
  // ****************************************************************
  typedef enum logic [1:0] {
    SFH_W1 = 2'b00,
    SFH_W2 = 2'b01,
    SFH_W4 = 2'b10
  } sfh_width_e;
  // ****************************************************************
  // host register map
  // ****************************************************************
  localparam logic [3:0] HR_CTRL   = 4'h0;
  localparam logic [3:0] HR_TXDATA = 4'h1;
  localparam logic [3:0] HR_RXDATA = 4'h2;
  localparam logic [3:0] HR_STATUS = 4'h3;
  localparam int CTRL_GO    = 0;
  localparam int CTRL_READ  = 1;
  localparam int CTRL_W_LO  = 2;
  localparam int CTRL_W_HI  = 3;
  localparam int CTRL_CS    = 4;
  localparam int CTRL_PAUSE = 5;
  localparam int CTRL_WPN   = 6;
  localparam int CTRL_MODE3 = 7;
  // link clock half period less one, in core cycles: 200 MHz / 8 = 25 MHz link clock
  localparam int CORE_MHZ   = 200;
  localparam int LINK_MHZ   = 25;
  localparam logic [3:0] HALF_DIV = 4'((CORE_MHZ / LINK_MHZ) / 2 - 1);
endpackage

// ### hdl/sfh_if.sv
// interface joining the flash device end and the host controller end
// assumes the bench resolves each lane from the two output enables
`timescale 1ns/1ps
interface sfh_if;
  logic       link_clk;
  logic       cs_b;
  logic [3:0] lane_h_o;
  logic [3:0] lane_h_oe;
  logic [3:0] lane_d_o;
  logic [3:0] lane_d_oe;
  logic [3:0] lane_i;
  modport dev
  (
    input  link_clk,
    input  cs_b,
    input  lane_i,
    output lane_d_o,
    output lane_d_oe
  );
  modport host
  (
    output link_clk,
    output cs_b,
    output lane_h_o,
    output lane_h_oe,
    input  lane_i
  );
endinterface // sfh_if

// ### hdl/sfh_sync.sv
// two flip-flop synchroniser for a bus of pin levels
// assumes inputs are asynchronous to core_clk
`timescale 1ns/1ps
module sfh_sync
#(
  parameter int W = 1
)
(
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      meta_reg <= '1;
      sync_out <= '1;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // sfh_sync

// ### hdl/sfh_dev.sv
// device end of the serial flash host port: lane roles, pause, protection
// assumes a host keeping mode 0 or 3 and the pause pin high when idle
`timescale 1ns/1ps
module sfh_dev
  import sfh_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  sfh_if.dev        lnk,
  input  wire logic [7:0] read_data,
  output logic      [7:0] cmd_opcode,
  output logic            cmd_valid,
  output logic      [7:0] wr_data,
  output logic            wr_valid,
  output logic            rd_taken,
  output logic            write_blocked,
  output logic      [7:0] protection_register,
  output logic            hw_protect_en,
  output logic            quad_active
);
  // ****************************************************************
  // pin sampling
  // ****************************************************************
  logic [5:0] pins_s;
  sfh_sync #(.W(6)) u_sync
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in ({lnk.link_clk, lnk.cs_b, lnk.lane_i}),
    .sync_out (pins_s)
  );
  logic       clk_s;
  logic       cs_s;
  logic [3:0] lane_s;
  logic       clk_d_reg;
  logic       seen_high_reg;
  logic       rise;
  logic       fall;
  assign clk_s  = pins_s[5];
  assign cs_s   = pins_s[4];
  assign lane_s = pins_s[3:0];
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      clk_d_reg <= 1'b0;
    else
      clk_d_reg <= clk_s;
  end
  assign rise = clk_s & ~clk_d_reg;
  assign fall = ~clk_s & clk_d_reg;
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      seen_high_reg <= 1'b0;
    else if (cs_s)
      seen_high_reg <= 1'b1;
  end
  logic active;
  assign active = seen_high_reg & ~cs_s;
  // ****************************************************************
  // pause
  // ****************************************************************
  // no pause in quad
  logic pause_req;
  logic paused_reg;
  // read the synced lane directly so the request follows every pin change
  assign pause_req = active & ~quad_active & ~lane_s[3];
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || !active)
      paused_reg <= 1'b0;
    else if (!clk_s || fall)
      paused_reg <= pause_req;
  end
  logic rise_ok;
  logic fall_ok;
  assign rise_ok = active & rise & ~paused_reg;
  assign fall_ok = active & fall & ~paused_reg;
  // ****************************************************************
  // shift engine
  // ****************************************************************
  sfh_width_e wid_reg;
  logic [7:0] sh_reg;
  logic [2:0] cnt_reg;
  logic       have_op_reg;
  logic       out_dir_reg;
  logic [7:0] tx_reg;
  logic [2:0] tx_cnt_reg;
  logic       byte_done;
  logic [7:0] sh_next;
  logic [2:0] step;
  always_comb
  begin
    unique case (wid_reg)
      SFH_W1:  begin sh_next = {sh_reg[6:0], lane_s[0]};   step = 3'h1; end
      SFH_W2:  begin sh_next = {sh_reg[5:0], lane_s[1:0]}; step = 3'h2; end
      SFH_W4:  begin sh_next = {sh_reg[3:0], lane_s};      step = 3'h4; end
      default: begin sh_next = sh_reg;                     step = 3'h1; end
    endcase
  end
  assign byte_done = rise_ok && (cnt_reg + step == 3'h0);
  function automatic sfh_width_e op_width(input logic [7:0] op);
    unique case (op)
      OP_DUAL_OUT, OP_DUAL_IO:                      return SFH_W2;
      OP_QUAD_OUT, OP_QUAD_IO, OP_QUAD_LD, OP_QUAD_LDR: return SFH_W4;
      default:                                      return SFH_W1;
    endcase
  endfunction
  sfh_width_e next_wid;
  assign next_wid = (hw_protect_en && op_width(sh_next) == SFH_W4)
                    ? SFH_W1 : op_width(sh_next);
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || !active)
    begin
      sh_reg      <= 8'h00;
      cnt_reg     <= 3'h0;
      have_op_reg <= 1'b0;
      wid_reg     <= SFH_W1;
      cmd_opcode  <= 8'h00;
    end
    else if (rise_ok)
    begin
      sh_reg  <= sh_next;
      cnt_reg <= cnt_reg + step;
      if (byte_done && !have_op_reg)
      begin
        have_op_reg <= 1'b1;
        cmd_opcode  <= sh_next;
        wid_reg     <= next_wid;
      end
    end
  end
  assign quad_active = active & (wid_reg == SFH_W4);
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cmd_valid <= 1'b0;
      wr_valid  <= 1'b0;
      wr_data   <= 8'h00;
    end
    else
    begin
      cmd_valid <= byte_done & ~have_op_reg;
      wr_valid  <= byte_done & have_op_reg & ~out_dir_reg;
      if (byte_done)
        wr_data <= sh_next;
    end
  end
  // ****************************************************************
  // protection
  // ****************************************************************
  logic wp_pin_low;
  logic wr_reg_op;
  assign wp_pin_low = ~lane_s[2] & ~quad_active;
  assign wr_reg_op  = have_op_reg & (cmd_opcode == OP_WRITE_REG);
  assign write_blocked = wp_pin_low & (hw_protect_en | wr_reg_op);
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      protection_register <= PR_RESET;
    else if (wr_valid && wr_reg_op && !write_blocked)
      protection_register <= wr_data;
  end
  assign hw_protect_en = protection_register[PR_HW_EN_BIT];
  // ****************************************************************
  // output lanes
  // ****************************************************************
  // dual out, quad out and register reads drive data once the opcode byte is in
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || !active)
      out_dir_reg <= 1'b0;
    else if (byte_done && !have_op_reg)
      out_dir_reg <= (sh_next == OP_DUAL_OUT) | (sh_next == OP_QUAD_OUT)
                   | (sh_next == OP_READ_REG);
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || !active)
    begin
      tx_reg     <= 8'h00;
      tx_cnt_reg <= 3'h0;
      rd_taken   <= 1'b0;
    end
    else
    begin
      rd_taken <= 1'b0;
      if (fall_ok && out_dir_reg)
      begin
        if (tx_cnt_reg == 3'h0)
        begin
          tx_reg   <= read_data;
          rd_taken <= 1'b1;
        end
        else
          tx_reg <= tx_reg << step;
        tx_cnt_reg <= tx_cnt_reg + step;
      end
    end
  end
  always_comb
  begin
    lnk.lane_d_o  = 4'h0;
    lnk.lane_d_oe = 4'h0;
    if (active && out_dir_reg && !paused_reg)
    begin
      unique case (wid_reg)
        SFH_W2:
        begin
          lnk.lane_d_o  = {2'b00, tx_reg[7:6]};
          lnk.lane_d_oe = 4'h3;
        end
        SFH_W4:
        begin
          lnk.lane_d_o  = tx_reg[7:4];
          lnk.lane_d_oe = 4'hF;
        end
        default:
        begin
          lnk.lane_d_o  = {2'b00, tx_reg[7], 1'b0};
          lnk.lane_d_oe = 4'h2;
        end
      endcase
    end
  end
endmodule // sfh_dev

// ### hdl/sfh_host.sv
// host end: makes link clock by divider, shifts bytes on one to four lanes
// assumes software writes ctrl then polls status busy
`timescale 1ns/1ps
module sfh_host
  import sfh_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  sfh_if.host             lnk,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata
);
  logic [7:0] ctrl_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [7:0] sh_reg;
  logic [3:0] div_reg;
  logic [2:0] cnt_reg;
  logic       busy_reg;
  logic       clk_reg;
  logic [3:0] lane_s;
  logic [2:0] step;
  logic       tick;
  logic [7:0] sh_cap;
  sfh_sync #(.W(4)) u_sync
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in (lnk.lane_i),
    .sync_out (lane_s)
  );
  always_comb
  begin
    unique case (ctrl_reg[CTRL_W_HI:CTRL_W_LO])
      SFH_W2:  step = 3'h2;
      SFH_W4:  step = 3'h4;
      default: step = 3'h1;
    endcase
  end
  always_comb
  begin
    unique case (step)
      3'h2:    sh_cap = {sh_reg[5:0], lane_s[1:0]};
      3'h4:    sh_cap = {sh_reg[3:0], lane_s};
      default: sh_cap = {sh_reg[6:0], lane_s[1]};
    endcase
  end
  // ****************************************************************
  // register port
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ctrl_reg <= 8'h50;
      tx_reg   <= 8'h00;
    end
    else if (wr && addr == HR_CTRL)
      ctrl_reg <= wdata;
    else if (wr && addr == HR_TXDATA)
      tx_reg <= wdata;
    else
      ctrl_reg[CTRL_GO] <= 1'b0;
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      rdata <= 8'h00;
    else if (rd)
      unique case (addr)
        HR_CTRL:   rdata <= ctrl_reg;
        HR_TXDATA: rdata <= tx_reg;
        HR_RXDATA: rdata <= rx_reg;
        HR_STATUS: rdata <= {7'h00, busy_reg};
        default:   rdata <= 8'h00;
      endcase
  end
  // ****************************************************************
  // link clock and shifter
  // ****************************************************************
  assign tick = busy_reg && div_reg == HALF_DIV;
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || !busy_reg)
      div_reg <= 4'h0;
    else
      div_reg <= tick ? 4'h0 : div_reg + 4'h1;
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      busy_reg <= 1'b0;
      clk_reg  <= 1'b0;
      cnt_reg  <= 3'h0;
      sh_reg   <= 8'h00;
      rx_reg   <= 8'h00;
    end
    else if (!busy_reg)
    begin
      clk_reg <= ctrl_reg[CTRL_MODE3];
      if (ctrl_reg[CTRL_GO] && !ctrl_reg[CTRL_CS])
      begin
        busy_reg <= 1'b1;
        sh_reg   <= tx_reg;
        cnt_reg  <= 3'h0;
        clk_reg  <= 1'b0;
      end
    end
    else if (tick && !clk_reg)
    begin
      // lanes hold across the rise so the device samples settled bits
      clk_reg <= 1'b1;
      cnt_reg <= cnt_reg + step;
    end
    else if (tick)
    begin
      // capture late: both synchronisers add a round trip of five cycles
      sh_reg <= sh_cap;
      if (cnt_reg == 3'h0)
      begin
        busy_reg <= 1'b0;
        rx_reg   <= sh_cap;
        clk_reg  <= ctrl_reg[CTRL_MODE3];
      end
      else
        clk_reg <= 1'b0;
    end
  end
  assign lnk.link_clk = clk_reg;
  assign lnk.cs_b     = ctrl_reg[CTRL_CS];
  always_comb
  begin
    lnk.lane_h_oe = 4'hC;
    lnk.lane_h_o  = {ctrl_reg[CTRL_PAUSE] ? 1'b0 : 1'b1,
                     ctrl_reg[CTRL_WPN], 2'b00};
    if (!ctrl_reg[CTRL_READ])
    begin
      unique case (step)
        3'h2:
        begin
          // lanes 2 and 3 keep their protect and pause levels in dual
          lnk.lane_h_o[1:0] = sh_reg[7:6];
          lnk.lane_h_oe = 4'hF;
        end
        3'h4:
        begin
          lnk.lane_h_o  = sh_reg[7:4];
          lnk.lane_h_oe = 4'hF;
        end
        default:
        begin
          lnk.lane_h_o[0]  = sh_reg[7];
          lnk.lane_h_oe[0] = 1'b1;
        end
      endcase
    end
    else if (step == 3'h4)
      lnk.lane_h_oe = 4'h0;
  end
endmodule // sfh_host

// ### tb/sfh_link_properties.sv
// checker of the link between the host end and the device end
// assumes it sits beside the joining interface, one core clock domain
`timescale 1ns/1ps
module sfh_link_chk
(
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       link_clk,
  input wire logic       cs_b,
  input wire logic [3:0] lane_h_o,
  input wire logic [3:0] lane_h_oe,
  input wire logic [3:0] lane_d_o,
  input wire logic [3:0] lane_d_oe,
  input wire logic [3:0] lane_i
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  logic       seen_sel_reg;
  logic       clk_prev_reg;
  logic [3:0] fall_age_reg;
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      seen_sel_reg <= 1'b0;
    else if (!cs_b)
      seen_sel_reg <= 1'b1;
  end
  always_ff @(posedge core_clk)
  begin
    clk_prev_reg <= link_clk;
  end
  // age since the last link clock fall; saturates so idle stays quiet
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      fall_age_reg <= 4'hF;
    else if (clk_prev_reg && !link_clk)
      fall_age_reg <= 4'h0;
    else if (fall_age_reg != 4'hF)
      fall_age_reg <= fall_age_reg + 4'h1;
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  // pause asked by the host while the link clock idles low
  sequence s_pause_req;
    (!cs_b && lane_h_oe[3] && !lane_h_o[3] && !link_clk) [*6];
  endsequence
  // device moves a driven lane without changing its enables
  sequence s_out_move;
    lane_d_oe != 4'h0 && $stable(lane_d_oe)
      && $changed(lane_d_o & lane_d_oe);
  endsequence
  a_desel_quiet:
    assert property (cs_b [*6] |-> lane_d_oe == 4'h0)
    else $error("device drives while deselected");
  a_desel_release:
    assert property ($rose(cs_b) |-> ##[1:5] lane_d_oe == 4'h0)
    else $error("device lanes not released after deselect");
  a_first_select:
    assert property (!seen_sel_reg |-> lane_d_oe == 4'h0)
    else $error("device drove before first select");
  a_mode_edges:
    assert property ($changed(cs_b) |-> $stable(link_clk) ##1
      $stable(link_clk))
    else $error("link clock moved at a select edge");
  a_host_hold_rise:
    assert property ($rose(link_clk) && !cs_b |->
      $stable(lane_h_o & lane_h_oe) [*4])
    else $error("host data moved near a rising edge");
  a_dev_out_fall:
    assert property (s_out_move |-> fall_age_reg <= 4'h5)
    else $error("device data moved away from a falling edge");
  a_pause_release:
    assert property (s_pause_req |=> lane_d_oe == 4'h0)
    else $error("device drives during pause");
  a_drive_needs_sel:
    assert property ($rose(lane_d_oe != 4'h0) |-> !cs_b)
    else $error("device started driving while deselected");
endmodule // sfh_link_chk

// ### tb/sfh_tb.sv
// self-checking bench: host end and device end joined by the interface
// assumes lanes resolve device first, then host, else pulled up
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
module testbench
  import sfh_pkg::*;
;
  logic       core_clk;
  logic       rst_b;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [7:0] read_data;
  logic [7:0] cmd_opcode;
  logic [7:0] wr_data;
  logic [7:0] protection_register;
  logic       write_blocked;
  logic       hw_protect_en;
  logic       quad_active;
  logic       cmd_valid;
  logic       wr_valid;
  logic       rd_taken;
  int         n_cmd = 0;
  int         n_wr = 0;
  int         n_rd = 0;
  int         bad_count = 0;
  int         checks = 0;
  int         cyc = 0;
  sfh_if sfh_if_i();
  // a clash on a lane shows the device value; the checker flags timing
  assign sfh_if_i.lane_i = (sfh_if_i.lane_d_oe & sfh_if_i.lane_d_o)
    | (~sfh_if_i.lane_d_oe & sfh_if_i.lane_h_oe & sfh_if_i.lane_h_o)
    | ~(sfh_if_i.lane_d_oe | sfh_if_i.lane_h_oe);
  sfh_host sfh_host_i
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .lnk      (sfh_if_i),
    .addr     (addr),
    .wdata    (wdata),
    .wr       (wr),
    .rd       (rd),
    .rdata    (rdata)
  );
  sfh_dev sfh_dev_i
  (
    .core_clk            (core_clk),
    .rst_b               (rst_b),
    .lnk                 (sfh_if_i),
    .read_data           (read_data),
    .cmd_opcode          (cmd_opcode),
    .cmd_valid           (cmd_valid),
    .wr_data             (wr_data),
    .wr_valid            (wr_valid),
    .rd_taken            (rd_taken),
    .write_blocked       (write_blocked),
    .protection_register (protection_register),
    .hw_protect_en       (hw_protect_en),
    .quad_active         (quad_active)
  );
  sfh_link_chk sfh_link_chk_i
  (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .link_clk  (sfh_if_i.link_clk),
    .cs_b      (sfh_if_i.cs_b),
    .lane_h_o  (sfh_if_i.lane_h_o),
    .lane_h_oe (sfh_if_i.lane_h_oe),
    .lane_d_o  (sfh_if_i.lane_d_o),
    .lane_d_oe (sfh_if_i.lane_d_oe),
    .lane_i    (sfh_if_i.lane_i)
  );
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // pulse counters for the one-cycle strobes of the device end
  always @(posedge core_clk)
  begin
    if (cmd_valid === 1'b1)
      n_cmd++;
    if (wr_valid === 1'b1)
      n_wr++;
    if (rd_taken === 1'b1)
      n_rd++;
  end
  // ****************************************************************
  // bus and frame tasks
  // ****************************************************************
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
  // one byte: load, go, poll busy with a bound, fetch what came back
  task automatic xfer(input logic [7:0] c, input logic [7:0] tx,
                      output logic [7:0] rx);
    logic [7:0] s;
    int         n;
    reg_wr(HR_TXDATA, tx);
    reg_wr(HR_CTRL, c);
    s = 8'h01;
    n = 0;
    while (s[0] !== 1'b0 && n < 300)
    begin
      reg_rd(HR_STATUS, s);
      n++;
    end
    `CHK("busy done", 1'b0, s[0])
    reg_rd(HR_RXDATA, rx);
  endtask
  task automatic frame_op(input logic [7:0] c, input logic [7:0] op);
    logic [7:0] rx;
    reg_wr(HR_CTRL, c);
    xfer(c | 8'h01, op, rx);
  endtask
  task automatic close(input logic [7:0] c);
    reg_wr(HR_CTRL, c | 8'h10);
    repeat (8) @(posedge core_clk);
  endtask
  task automatic t_read(input logic [7:0] c, input logic [7:0] op,
                        input logic [7:0] rc, input logic [7:0] exp);
    logic [7:0] rx;
    int         n0;
    @(posedge core_clk);
    read_data <= exp;
    n0 = n_rd;
    frame_op(c, op);
    `CHK("opcode", op, cmd_opcode)
    xfer(rc, 8'h00, rx);
    `CHK("read byte", exp, rx)
    close(c);
    `CHK("rd taken", (c[CTRL_MODE3] ? 1 : 2), n_rd - n0)
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [7:0] v;
    `CHK("lane oe", 4'h0, sfh_if_i.lane_d_oe)
    `CHK("prot reg", PR_RESET, protection_register)
    `CHK("hw enable", 1'b0, hw_protect_en)
    reg_rd(4'hF, v);
    `CHK("unmapped", 8'h00, v)
  endtask
  task automatic t_opcodes;
    logic [7:0] ops [6];
    logic       quad [6];
    int         n0;
    ops = '{OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT, OP_QUAD_IO,
            OP_QUAD_LD, OP_QUAD_LDR};
    quad = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    foreach (ops[k])
    begin
      n0 = n_cmd;
      frame_op(8'h40, ops[k]);
      `CHK("cmd pulse", n0 + 1, n_cmd)
      `CHK("opcode", ops[k], cmd_opcode)
      `CHK("quad", quad[k], quad_active)
      close(8'h40);
    end
  endtask
  task automatic t_pause;
    logic [7:0] rx;
    @(posedge core_clk);
    read_data <= 8'hC3;
    frame_op(8'h40, OP_DUAL_OUT);
    reg_wr(HR_CTRL, 8'h66);
    repeat (10) @(posedge core_clk);
    `CHK("pause oe", 4'h0, sfh_if_i.lane_d_oe)
    reg_wr(HR_CTRL, 8'h46);
    repeat (10) @(posedge core_clk);
    xfer(8'h47, 8'h00, rx);
    `CHK("resumed", 8'hC3, rx)
    close(8'h40);
  endtask
  task automatic t_protect;
    logic [7:0] rx;
    int         n0;
    frame_op(8'h00, OP_WRITE_REG);
    xfer(8'h01, 8'h7E, rx);
    `CHK("soft block", 1'b1, write_blocked)
    `CHK("guarded", PR_RESET, protection_register)
    close(8'h40);
    frame_op(8'h40, OP_WRITE_REG);
    n0 = n_wr;
    xfer(8'h41, 8'h7E, rx);
    `CHK("wr pulse", n0 + 1, n_wr)
    `CHK("write byte", 8'h7E, wr_data)
    close(8'h40);
    `CHK("prot reg", 8'h7E, protection_register)
    `CHK("hw enable", 1'b1, hw_protect_en)
    reg_wr(HR_CTRL, 8'h10);
    repeat (8) @(posedge core_clk);
    `CHK("hw block", 1'b1, write_blocked)
    reg_wr(HR_CTRL, 8'h50);
    frame_op(8'h40, OP_QUAD_OUT);
    `CHK("quad off", 1'b0, quad_active)
    close(8'h40);
    frame_op(8'h40, OP_WRITE_REG);
    xfer(8'h41, PR_RESET, rx);
    close(8'h40);
    `CHK("hw cleared", 1'b0, hw_protect_en)
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // a hung handshake is cut short far beyond the expected run length
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      end_of_test;
    end
  end
  initial
  begin
    rst_b     = 1'b0;
    addr      = 4'h0;
    wdata     = 8'h00;
    wr        = 1'b0;
    rd        = 1'b0;
    read_data = 8'h00;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset;
    t_read(8'h40, OP_READ_REG, 8'h43, 8'h7C);
    t_read(8'h40, OP_DUAL_OUT, 8'h47, 8'hA6);
    t_read(8'h40, OP_QUAD_OUT, 8'h4B, 8'h5B);
    t_opcodes;
    t_pause;
    t_protect;
    reg_wr(HR_CTRL, 8'hD0);
    t_read(8'hC0, OP_READ_REG, 8'hC3, 8'h7C);
    reg_wr(HR_CTRL, 8'h50);
    end_of_test;
  end
endmodule // testbench
